// File: hdl/pif_defs.vh
/*
  constants for the peripheral interrupt flag block: register byte
  offsets, flag bit positions, reset values and capture/compare modes.
  assumes inclusion by bare name from the design file.
*/
`ifndef PIF_DEFS_VH
`define PIF_DEFS_VH

// register byte addresses on the axi4-lite bus
`define PIF_FLAGS_A_ADDR   4'h0
`define PIF_FLAGS_B_ADDR   4'h4
`define PIF_MODE_ADDR      4'h8
`define PIF_RX_BUF_ADDR    4'hc

// flag positions in flags a
`define PIF_A_TIMER_ONE_COUNT_BIT     0
`define PIF_A_TIMER_TWO_COUNT_BIT     1
`define PIF_A_CCPA_BIT     2
`define PIF_A_SYNC_BIT     3
`define PIF_A_TX_BIT       4
`define PIF_A_RX_BIT       5

// flag positions in flags b
`define PIF_B_CCPB_BIT     0
`define PIF_B_TIMER_THREE_COUNT_BIT     1
`define PIF_B_LV_BIT       2
`define PIF_B_BCOL_BIT     3

// mask of software-clearable bits
`define PIF_A_SW_MASK      8'h0f
`define PIF_B_SW_MASK      8'h0f

// reset values
`define PIF_FLAGS_RESET    8'h00
`define PIF_MODE_RESET     4'h0

// capture/compare unit modes
`define PIF_MODE_OFF       2'h0
`define PIF_MODE_CAPTURE   2'h1
`define PIF_MODE_COMPARE   2'h2
`define PIF_MODE_PWM       2'h3

// axi responses
`define PIF_RESP_OKAY      2'h0
`define PIF_RESP_SLVERR    2'h2

`endif

// File: hdl/pif_flags.v
/*
  peripheral interrupt flag registers a and b with an axi4-lite slave.
  assumes event inputs are one-cycle pulses or levels from logic on aclk,
  except low_voltage_in, which comes from an analog detector.
  the bus side keeps one write and one read in flight at most; only the
  low byte lane carries register data, and wstrb[0] gates every write.
*/
// Chosen here: register access over AXI4-Lite and the address map.
`include "pif_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module pif_flags (
  input  wire        aclk,            // system clock
  input  wire        aresetn,         // synchronous reset, active low
  input  wire [3:0]  s_axi_awaddr,    // write address
  input  wire        s_axi_awvalid,   // write address valid
  output wire        s_axi_awready,   // write address ready
  input  wire [31:0] s_axi_wdata,     // write data
  input  wire [3:0]  s_axi_wstrb,     // write byte strobes
  input  wire        s_axi_wvalid,    // write data valid
  output wire        s_axi_wready,    // write data ready
  output reg  [1:0]  s_axi_bresp,     // write response
  output reg         s_axi_bvalid,    // write response valid
  input  wire        s_axi_bready,    // write response ready
  input  wire [3:0]  s_axi_araddr,    // read address
  input  wire        s_axi_arvalid,   // read address valid
  output wire        s_axi_arready,   // read address ready
  output reg  [31:0] s_axi_rdata,     // read data
  output reg  [1:0]  s_axi_rresp,     // read response
  output reg         s_axi_rvalid,    // read data valid
  input  wire        s_axi_rready,    // read data ready
  input  wire        rx_word_in,      // receiver delivers a word, pulse
  input  wire [7:0]  rx_data_in,      // received word
  input  wire        tx_taken_in,     // transmitter took the tx word, pulse
  output reg         tx_write_out,    // tx buffer written, pulse
  output reg  [7:0]  tx_data_out,     // word written to tx buffer
  input  wire        sync_done_in,    // sync port transfer done, pulse
  input  wire        bus_collision_in,// sync port bus collision, pulse
  input  wire        capcmp_a_capture_in, // unit a capture, pulse
  input  wire        capcmp_b_capture_in, // unit b capture, pulse
  input  wire        timer_one_count_ovf_in, // timer one wraps, pulse
  input  wire [15:0] timer_one_count, // timer one count
  input  wire [15:0] capcmp_a_compare_in, // unit a compare value
  input  wire [15:0] capcmp_b_compare_in, // unit b compare value
  input  wire [7:0]  timer_two_count, // timer two count
  input  wire [7:0]  timer_two_period,// timer two period
  input  wire [15:0] timer_three_count, // timer three count
  input  wire        low_voltage_in   // detector: supply low, async level
);

  // flag, buffer and mode state
  reg  [7:0]  flags_a_reg;
  reg  [7:0]  flags_b_reg;
  reg  [3:0]  mode_reg;               // [1:0] unit a mode, [3:2] unit b mode
  reg  [7:0]  rx_buf_reg;
  reg         rx_full_reg;
  reg         tx_empty_reg;
  reg  [15:0] timer_three_count_prev_reg;
  reg  [7:0]  timer_two_count_prev_reg;
  reg  [15:0] timer_one_count_prev_reg;
  reg         lv_meta_reg;
  reg         lv_sync_reg;

  // write channel holding registers
  reg         aw_hold_reg;
  reg  [3:0]  aw_addr_reg;
  reg         w_hold_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;

  // combinational terms
  reg  [7:0]  set_a;
  reg  [7:0]  set_b;
  reg  [31:0] rd_word;
  reg  [1:0]  rd_resp;
  wire        wr_go;
  wire        rd_go;
  wire        wr_a;
  wire        wr_b;
  wire [1:0]  mode_a;
  wire [1:0]  mode_b;
  wire        match_a;
  wire        match_b;

  // address decodes and sticky next values
  wire [3:0]  rd_addr;                // read address on a word boundary
  wire        rd_buf;                 // read of the receive buffer
  wire        wr_buf;                 // write of the transmit buffer
  wire        wr_mode;                // write of the mode register
  wire [3:0]  flags_a_next;           // sticky low nibble of flags a
  wire [3:0]  flags_b_next;           // sticky low nibble of flags b
  genvar      i;

  // a write fires once address and data are both held
  assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_go  = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  assign rd_go  = s_axi_arvalid & ~s_axi_rvalid;
  assign wr_a   = wr_go & (aw_addr_reg == `PIF_FLAGS_A_ADDR) & w_strb_reg[0];
  assign wr_b   = wr_go & (aw_addr_reg == `PIF_FLAGS_B_ADDR) & w_strb_reg[0];
  assign mode_a = mode_reg[1:0];
  assign mode_b = mode_reg[3:2];
  // compare match: count steps onto the compare value
  assign match_a = (timer_one_count == capcmp_a_compare_in) &
                   (timer_one_count_prev_reg != capcmp_a_compare_in);
  assign match_b = (timer_one_count == capcmp_b_compare_in) &
                   (timer_one_count_prev_reg != capcmp_b_compare_in);
  // word address decodes, so an unaligned read aliases like the mux does
  assign rd_addr = {s_axi_araddr[3:2], 2'b00};
  assign rd_buf  = rd_go & (rd_addr == `PIF_RX_BUF_ADDR);
  assign wr_buf  = wr_go & (aw_addr_reg == `PIF_RX_BUF_ADDR) & w_strb_reg[0];
  assign wr_mode = wr_go & (aw_addr_reg == `PIF_MODE_ADDR) & w_strb_reg[0];

  // hardware set terms for each sticky flag
  always @* begin
    set_a = 8'h00;
    set_b = 8'h00;
    set_a[`PIF_A_TIMER_ONE_COUNT_BIT] = timer_one_count_ovf_in;
    set_a[`PIF_A_TIMER_TWO_COUNT_BIT] = (timer_two_count == timer_two_period) &
                             (timer_two_count_prev_reg != timer_two_period);
    set_a[`PIF_A_CCPA_BIT] =
      ((mode_a == `PIF_MODE_CAPTURE) & capcmp_a_capture_in) |
      ((mode_a == `PIF_MODE_COMPARE) & match_a);
    set_a[`PIF_A_SYNC_BIT] = sync_done_in;
    set_b[`PIF_B_CCPB_BIT] =
      ((mode_b == `PIF_MODE_CAPTURE) & capcmp_b_capture_in) |
      ((mode_b == `PIF_MODE_COMPARE) & match_b);
    set_b[`PIF_B_TIMER_THREE_COUNT_BIT] = (timer_three_count == 16'h0000) &
                             (timer_three_count_prev_reg == 16'hffff);
    set_b[`PIF_B_LV_BIT]   = lv_sync_reg;
    set_b[`PIF_B_BCOL_BIT] = bus_collision_in;
  end

  // per-bit sticky next value: a written zero clears, a set term wins
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_sticky
      assign flags_a_next[i] = (wr_a ? (flags_a_reg[i] & w_data_reg[i])
                                     : flags_a_reg[i]) | set_a[i];
      assign flags_b_next[i] = (wr_b ? (flags_b_reg[i] & w_data_reg[i])
                                     : flags_b_reg[i]) | set_b[i];
    end
  endgenerate

  // sticky flags: set wins over a software clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      flags_a_reg <= `PIF_FLAGS_RESET;
      flags_b_reg <= `PIF_FLAGS_RESET;
    end else begin
      flags_a_reg[3:0] <= flags_a_next;
      flags_a_reg[7:4] <= {2'b00, rx_full_reg, tx_empty_reg};
      flags_b_reg[3:0] <= flags_b_next;
      flags_b_reg[7:4] <= 4'h0;
    end
  end

  // count history for the edge detectors; it tracks the counts through
  // reset so that a count already on its match value raises no flag
  always @(posedge aclk) begin
    timer_one_count_prev_reg <= timer_one_count;
    timer_two_count_prev_reg <= timer_two_count;
    timer_three_count_prev_reg <= timer_three_count;
  end

  // two-flop synchroniser for the detector level from outside aclk
  always @(posedge aclk) begin
    if (!aresetn) begin
      lv_meta_reg <= 1'b0;
      lv_sync_reg <= 1'b0;
    end else begin
      lv_meta_reg <= low_voltage_in;
      lv_sync_reg <= lv_meta_reg;
    end
  end

  // receive buffer: a new word wins over a read in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_full_reg <= 1'b0;
      rx_buf_reg  <= 8'h00;
    end else if (rx_word_in) begin
      rx_full_reg <= 1'b1;
      rx_buf_reg  <= rx_data_in;
    end else if (rd_buf) begin
      rx_full_reg <= 1'b0;
    end
  end

  // transmit buffer: a software write wins over the transmitter taking
  // the old word, since the buffer then holds a fresh one
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_empty_reg <= 1'b1;
      tx_write_out <= 1'b0;
      tx_data_out  <= 8'h00;
    end else begin
      tx_write_out <= wr_buf;
      if (wr_buf) begin
        tx_empty_reg <= 1'b0;
        tx_data_out  <= w_data_reg[7:0];
      end else if (tx_taken_in) begin
        tx_empty_reg <= 1'b1;
      end
    end
  end

  // capture/compare mode register, one nibble in the low byte lane
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= `PIF_MODE_RESET;
    end else if (wr_mode) begin
      mode_reg <= w_data_reg[3:0];
    end
  end

  // write address: held from its handshake until the pair goes
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= {s_axi_awaddr[3:2], 2'b00};
    end else if (wr_go) begin
      aw_hold_reg <= 1'b0;
    end
  end

  // write data: held from its handshake until the pair goes
  always @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_go) begin
      w_hold_reg <= 1'b0;
    end
  end

  // write response: every write answers okay, unmapped ones do nothing
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PIF_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= `PIF_RESP_OKAY;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read data mux
  always @* begin
    rd_resp = `PIF_RESP_OKAY;
    case (rd_addr)
      `PIF_FLAGS_A_ADDR: rd_word = {24'h000000, flags_a_reg};
      `PIF_FLAGS_B_ADDR: rd_word = {24'h000000, 4'h0, flags_b_reg[3:0]};
      `PIF_MODE_ADDR:    rd_word = {28'h0000000, mode_reg};
      `PIF_RX_BUF_ADDR:  rd_word = {24'h000000, rx_buf_reg};
      default: begin
        rd_word = 32'h00000000;
        rd_resp = `PIF_RESP_SLVERR;
      end
    endcase
  end

  // read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `PIF_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_resp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // pif_flags

`default_nettype wire

// File: tb/pif_checker.sv
/*
  bus handshake and tx strobe assertions for the flag block.
  assumes it is bound into pif_flags and sees only its ports.
*/
`include "pif_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module pif_checker (
  input wire logic        aclk, aresetn,                // clock, reset
  input wire logic [3:0]  s_axi_awaddr, s_axi_wstrb,    // write side
  input wire logic [3:0]  s_axi_araddr,                 // read address
  input wire logic        s_axi_awvalid, s_axi_awready, // write address
  input wire logic        s_axi_wvalid, s_axi_wready,   // write data
  input wire logic        s_axi_bvalid, s_axi_bready,   // write response
  input wire logic        s_axi_arvalid, s_axi_arready, // read address
  input wire logic        s_axi_rvalid, s_axi_rready,   // read data
  input wire logic [31:0] s_axi_rdata,                  // read word
  input wire logic        tx_write_out                  // tx strobe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // read taken, and a tx buffer write with wstrb[0] set taken
  wire ar_go = s_axi_arvalid && s_axi_arready;
  wire tx_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
               s_axi_wready && s_axi_awaddr == `PIF_RX_BUF_ADDR &&
               s_axi_wstrb[0];
  chk_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read ready wrong");
  chk_read_lat: assert property (ar_go |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write answer dropped");
  chk_write_block: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  chk_flags_a_hi: assert property (ar_go &&
    s_axi_araddr == `PIF_FLAGS_A_ADDR |=> s_axi_rdata[31:6] == 26'h0)
    else $error("flags a high bits set");
  chk_flags_b_hi: assert property (ar_go &&
    s_axi_araddr == `PIF_FLAGS_B_ADDR |=> s_axi_rdata[31:4] == 28'h0)
    else $error("flags b high bits set");
  chk_tx_cause: assert property (tx_go |-> ##[1:2] tx_write_out)
    else $error("tx strobe missing");
  chk_tx_pulse: assert property (tx_write_out |=> !tx_write_out)
    else $error("tx strobe too long");
endmodule // pif_checker
bind pif_flags pif_checker i_chk (.*);
`default_nettype wire

// File: tb/pif_periph.sv
/*
  peripheral event sources facing the flag block.
  assumes the bench raises a request bit for one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pif_periph (
  input  wire logic       aclk,     // system clock
  input  wire logic [6:0] ev_req,   // rx,txe,sync,bcol,capa,capb,t1ovf
  input  wire logic [7:0] rx_val,   // word to deliver
  output var  logic [6:0] ev_pulse, // one-cycle event pulses
  output var  logic [7:0] rx_data   // received word, valid with pulse
);
  initial ev_pulse = 7'h00;
  initial rx_data = 8'h00;
  // pulses last one clock; word is junk outside its pulse
  always @(posedge aclk) begin
    ev_pulse <= ev_req;
    rx_data  <= ev_req[0] ? rx_val : ~rx_data;
  end
endmodule // pif_periph
`default_nettype wire

// File: tb/test_pif_flags.sv
/*
  register-level bench for the flag block over axi4-lite.
  assumes pif_flags, pif_periph and the bound checker.
*/
`include "pif_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module test_pif_flags;
  localparam [3:0] fa = `PIF_FLAGS_A_ADDR, fb = `PIF_FLAGS_B_ADDR;
  localparam [3:0] md = `PIF_MODE_ADDR, bf = `PIF_RX_BUF_ADDR;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic lv = 0;
  logic [3:0]  aw = 0, ar = 0, ws = 4'hf;
  logic [31:0] wd = 0, rdv;
  logic [1:0]  rsp, wsp;
  logic [15:0] t1 = 0, t3 = 0, cmpa = 16'h1234, cmpb = 16'h1235;
  logic [7:0]  t2 = 0, p2 = 8'h20, rx_val = 0;
  logic [6:0]  ev_req = 0;
  wire  [6:0]  evp;
  wire  [7:0]  rxd, txd;
  wire  [31:0] rdata;
  wire  [1:0]  bresp, rresp;
  wire         awr, wrd, bv, arr, rv, txw;
  int failures = 0, samples_checked = 0, cyc = 0;
  always #5 aclk = ~aclk;
  pif_periph i_per (.aclk(aclk), .ev_req(ev_req), .rx_val(rx_val),
    .ev_pulse(evp), .rx_data(rxd));
  pif_flags i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .rx_word_in(evp[0]), .rx_data_in(rxd),
    .tx_taken_in(evp[1]), .tx_write_out(txw), .tx_data_out(txd),
    .sync_done_in(evp[2]), .bus_collision_in(evp[3]),
    .capcmp_a_capture_in(evp[4]), .capcmp_b_capture_in(evp[5]),
    .timer_one_count_ovf_in(evp[6]), .timer_one_count(t1),
    .capcmp_a_compare_in(cmpa), .capcmp_b_compare_in(cmpb),
    .timer_two_count(t2), .timer_two_period(p2),
    .timer_three_count(t3), .low_voltage_in(lv));
  task close_out;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("wrong value at %0t: %h expected %h", $time, s, e);
    end
  endtask
  // each channel released at the edge it is taken
  task bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    aw <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end while (!bv);
    wsp = bresp;
    br <= 0;
  endtask
  task bus_rd(input logic [3:0] a);
    @(posedge aclk);
    ar <= a; arv <= 1; rr <= 1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 0;
    end while (!rv);
    rdv = rdata;
    rsp = rresp;
    rr <= 0;
  endtask
  task rd_chk(input logic [3:0] a, input logic [31:0] e);
    bus_rd(a);
    chk(rdv, e);
  endtask
  // one event request, then time for the flag to land
  task ev(input logic [6:0] m);
    @(posedge aclk);
    ev_req <= m;
    @(posedge aclk);
    ev_req <= 0;
    repeat (3) @(posedge aclk);
  endtask
  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      close_out;
    end
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rd_chk(fa, 32'h10);
    rd_chk(fb, 32'h00);
    bus_wr(md, 32'h5);
    chk({30'h0, wsp}, {30'h0, `PIF_RESP_OKAY});
    ev(7'h7c);
    rd_chk(fa, 32'h1d);
    rd_chk(fb, 32'h09);
    @(posedge aclk);
    t2 <= 8'h20; t3 <= 16'hffff;
    @(posedge aclk);
    t3 <= 16'h0; lv <= 1;
    repeat (6) @(posedge aclk);
    rd_chk(fa, 32'h1f);
    lv <= 0;
    rd_chk(fb, 32'h0f);
    rd_chk(fb, 32'h0f);
    bus_wr(fa, 32'h0);
    rd_chk(fa, 32'h10);
    ws <= 4'he;
    bus_wr(fb, 32'h0);
    ws <= 4'hf;
    rd_chk(fb, 32'h0f);
    bus_wr(fb, 32'hfb);
    rd_chk(fb, 32'h0b);
    rx_val <= 8'h5a;
    ev(7'h01);
    rd_chk(fa, 32'h30);
    rd_chk(bf, 32'h5a);
    rd_chk(fa, 32'h10);
    bus_wr(bf, 32'h33);
    chk({24'h0, txd}, 32'h33);
    rd_chk(fa, 32'h00);
    ev(7'h02);
    rd_chk(fa, 32'h10);
    bus_wr(fb, 32'h0);
    bus_wr(md, 32'ha);
    t1 <= 16'h1234;
    @(posedge aclk);
    t1 <= 16'h1235;
    repeat (3) @(posedge aclk);
    rd_chk(fa, 32'h14);
    rd_chk(fb, 32'h01);
    bus_wr(fa, 32'h0);
    bus_wr(fb, 32'h0);
    bus_wr(md, 32'hf);
    ev(7'h30);
    rd_chk(fa, 32'h10);
    rd_chk(fb, 32'h00);
    rd_chk(md, 32'hf);
    rd_chk(4'h1, 32'h10);
    chk({30'h0, rsp}, {30'h0, `PIF_RESP_OKAY});
    close_out;
  end
endmodule // test_pif_flags
`default_nettype wire
